// file: rtl/bcd_time_counter.sv
`timescale 1ns/10ps
module bcd_time_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Count and load
  input wire logic sec_pulse,
  input wire logic load,
  input wire logic [calendar_clock_unit_pkg::TIME_W-1:0] load_value,
  // Time out
  output logic [calendar_clock_unit_pkg::TIME_W-1:0] time_value,
  output logic minute_roll
);

  typedef struct packed {
    logic [calendar_clock_unit_pkg::TIME_W-1:0] t;
    logic roll;
  } time_state_s;

  time_state_s s;
  time_state_s n;

  // BCD ripple count: ss, then mm, then hh with 23 wrapping to 00
  always_comb begin
    n = s;
    n.roll = 1'b0;
    if (load) begin
      n.t = load_value;
    end else if (sec_pulse) begin
      n.t[3:0] = calendar_clock_unit_pkg::bcd_next(s.t[3:0], 4'h9);
      if (s.t[3:0] == 4'h9) begin
        n.t[7:4] = calendar_clock_unit_pkg::bcd_next(s.t[7:4], 4'h5);
        if (s.t[7:0] == 8'h59) begin
          n.roll = 1'b1;
          n.t[11:8] = calendar_clock_unit_pkg::bcd_next(s.t[11:8], 4'h9);
          if (s.t[11:8] == 4'h9) begin
            n.t[15:12] = calendar_clock_unit_pkg::bcd_next(s.t[15:12], 4'h5);
            if (s.t[15:8] == 8'h59) begin
              if (s.t[23:16] == 8'h23) begin
                n.t[23:16] = 8'h00;
              end else begin
                n.t[19:16] = calendar_clock_unit_pkg::bcd_next(s.t[19:16], 4'h9);
                if (s.t[19:16] == 4'h9) n.t[23:20] = calendar_clock_unit_pkg::bcd_next(s.t[23:20], 4'h2);
              end
            end
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign time_value = s.t;
  assign minute_roll = s.roll;

endmodule : bcd_time_counter

// file: rtl/calendar_clock_unit_pkg.sv
package calendar_clock_unit_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TB_PERIOD_NS = 30518;
  // Timebase period in core cycles, rounded up
  localparam int TB_PERIOD_CYC = (TB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Two missed timebase periods mean the timebase has stopped
  localparam int RUN_TIMEOUT_CYC = 2 * TB_PERIOD_CYC;
  localparam int RUN_W = $clog2(RUN_TIMEOUT_CYC + 1);
  localparam int TICKS_PER_SEC = 32768;
  localparam int SYNC_WINDOW_TICKS = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIME = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int TRIM_W = 10;
  localparam int CTRL_TRIM_LSB = 16;
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_IDLE_BIT = 13;
  localparam int CTRL_SEL_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int CTRL_UNLOCK_BIT = 3;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int CTRL_HALF_BIT = 1;
  localparam int CTRL_OE_BIT = 0;
  localparam logic [31:0] CTRL_RSVD_MASK = 32'hFC00_5F30;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Time register fields: hh mm ss, four bits a digit
  localparam int TIME_W = 24;
  localparam int TIME_LSB = 8;
  localparam logic [TIME_W-1:0] TIME_RESET = 24'h00_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status bits
  localparam int INT_W = 3;
  localparam int EV_SEC = 0;
  localparam int EV_MIN = 1;
  localparam int EV_ALARM = 2;

  // Trim correction phase within a minute
  typedef enum logic [1:0] {TRIM_IDLE, TRIM_ADD, TRIM_DROP} trim_mode_e;

  // Next BCD digit with wrap at the given last value
  function automatic logic [3:0] bcd_next(input logic [3:0] d, input logic [3:0] last);
    bcd_next = (d >= last) ? 4'h0 : 4'(d + 4'h1);
  endfunction : bcd_next

endpackage : calendar_clock_unit_pkg

// file: rtl/rtc_control_calibration.sv
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
// What this block does
// - Trim is signed 10-bit: add or remove pulses
// - All ones removes one; zero means no correction
// - Enable bit 15 runs or halts the unit
// - Enable writes ignored unless write unlock set
// - Unlock sets only after system write sequence
// - Idle halt gates bus clock during idle
// - Bit 7 picks seconds clock or alarm
// - Pin driven only while output enable set
// - Bit 6 shows timebase really running
// - Half flag read-only, cleared on seconds write
// - Control register resets only at power-on
// - Unimplemented control bits read as zero
// - Time register holds BCD hh mm ss
// - Time writes accepted only while unlocked
module rtc_control_calibration #(
  parameter int TICKS_PER_SEC = calendar_clock_unit_pkg::TICKS_PER_SEC
) (
  // Clock and power-on reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // System status
  input wire logic SYS_WRITE_UNLOCKED,
  input wire logic CPU_IDLE,
  input wire logic ALARM_PULSE,
  // Timebase pin
  input wire logic TIMEBASE_IN,
  // Output pin
  output logic RTC_PIN_OUT,
  output logic RTC_PIN_OE,
  // Bus clock gate and interrupt
  output logic BUS_CLK_EN,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [2:0] tb_sync;
    logic tb_level;
    logic [calendar_clock_unit_pkg::TRIM_W-1:0] trim;
    logic on;
    logic idle_halt;
    logic sel;
    logic unlock;
    logic oe;
    logic [calendar_clock_unit_pkg::RUN_W-1:0] run_cnt;
    logic running;
    logic bus_clk_en;
    logic [31:0] rdata;
    logic [calendar_clock_unit_pkg::INT_W-1:0] int_stat;
    logic [calendar_clock_unit_pkg::INT_W-1:0] int_mask;
    logic pin_out;
    logic alarm_d;
  } ctrl_state_s;

  ctrl_state_s s;
  ctrl_state_s n;

  logic tb_stable;
  logic tick;
  logic wr_ok;
  logic rd_ok;
  logic time_load;
  logic sec_pulse;
  logic half_flag;
  logic near_roll;
  logic minute_roll;
  logic alarm_rise;
  logic [calendar_clock_unit_pkg::TIME_W-1:0] time_value;
  logic [calendar_clock_unit_pkg::INT_W-1:0] events;
  logic [31:0] ctrl_word;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase edge detection and bus qualification

  // Level changes once the second and third stages agree
  assign tb_stable = (s.tb_sync[1] == s.tb_sync[2]);
  assign tick = tb_stable && s.tb_sync[2] && !s.tb_level;

  // Accesses only count while the bus clock reaches the unit
  assign wr_ok = WR && s.bus_clk_en;
  assign rd_ok = RD && s.bus_clk_en;
  assign time_load = wr_ok && (ADDR == calendar_clock_unit_pkg::OFS_TIME) && s.unlock;
  assign alarm_rise = ALARM_PULSE && !s.alarm_d;
  assign events = {alarm_rise, minute_roll, sec_pulse};

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  rtc_prescaler #(
    .TICKS_PER_SEC(TICKS_PER_SEC)
  ) u_prescaler (
    .clk(CORE_CLK),
    .rst(RST),
    .tick(tick),
    .run(s.on),
    .trim(s.trim),
    .minute_roll(minute_roll),
    .clear_half(time_load),
    .sec_pulse(sec_pulse),
    .half_flag(half_flag),
    .near_roll(near_roll)
  );

  bcd_time_counter u_time (
    .clk(CORE_CLK),
    .rst(RST),
    .sec_pulse(sec_pulse),
    .load(time_load),
    .load_value(WDATA[calendar_clock_unit_pkg::TIME_LSB +: calendar_clock_unit_pkg::TIME_W]),
    .time_value(time_value),
    .minute_roll(minute_roll)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control word as software reads it; other bits stay zero

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[calendar_clock_unit_pkg::CTRL_TRIM_LSB +: calendar_clock_unit_pkg::TRIM_W] = s.trim;
    ctrl_word[calendar_clock_unit_pkg::CTRL_ON_BIT] = s.on;
    ctrl_word[calendar_clock_unit_pkg::CTRL_IDLE_BIT] = s.idle_halt;
    ctrl_word[calendar_clock_unit_pkg::CTRL_SEL_BIT] = s.sel;
    ctrl_word[calendar_clock_unit_pkg::CTRL_RUN_BIT] = s.running;
    ctrl_word[calendar_clock_unit_pkg::CTRL_UNLOCK_BIT] = s.unlock;
    ctrl_word[calendar_clock_unit_pkg::CTRL_SYNC_BIT] = s.on && near_roll;
    ctrl_word[calendar_clock_unit_pkg::CTRL_HALF_BIT] = half_flag;
    ctrl_word[calendar_clock_unit_pkg::CTRL_OE_BIT] = s.oe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = s;
    n.tb_sync = {s.tb_sync[1:0], TIMEBASE_IN};
    if (tb_stable) n.tb_level = s.tb_sync[2];
    n.alarm_d = ALARM_PULSE;

    // Control register writes
    if (wr_ok && ADDR == calendar_clock_unit_pkg::OFS_CTRL) begin
      n.trim = WDATA[calendar_clock_unit_pkg::CTRL_TRIM_LSB +: calendar_clock_unit_pkg::TRIM_W];
      n.idle_halt = WDATA[calendar_clock_unit_pkg::CTRL_IDLE_BIT];
      n.sel = WDATA[calendar_clock_unit_pkg::CTRL_SEL_BIT];
      n.oe = WDATA[calendar_clock_unit_pkg::CTRL_OE_BIT];
      if (s.unlock) n.on = WDATA[calendar_clock_unit_pkg::CTRL_ON_BIT];
      // Clearing is always allowed, setting needs the system sequence
      n.unlock = WDATA[calendar_clock_unit_pkg::CTRL_UNLOCK_BIT] && (SYS_WRITE_UNLOCKED || s.unlock);
    end

    // Timebase watchdog: running only while ticks keep coming
    if (!s.on) begin
      n.run_cnt = '0;
    end else if (tick) begin
      n.run_cnt = calendar_clock_unit_pkg::RUN_W'(calendar_clock_unit_pkg::RUN_TIMEOUT_CYC);
    end else if (s.run_cnt != '0) begin
      n.run_cnt = s.run_cnt - 1'b1;
    end
    n.running = n.on && (n.run_cnt != '0);

    // Bus clock gate while idle
    n.bus_clk_en = !(n.idle_halt && CPU_IDLE);

    // Sticky status: a new event wins over a same-cycle clear
    if (wr_ok && ADDR == calendar_clock_unit_pkg::OFS_INT_STAT) begin
      n.int_stat = (s.int_stat & ~WDATA[calendar_clock_unit_pkg::INT_W-1:0]) | events;
    end else begin
      n.int_stat = s.int_stat | events;
    end
    if (wr_ok && ADDR == calendar_clock_unit_pkg::OFS_INT_MASK) n.int_mask = WDATA[calendar_clock_unit_pkg::INT_W-1:0];

    // Output pin source
    if (s.oe) begin
      n.pin_out = s.sel ? half_flag : ALARM_PULSE;
    end else begin
      n.pin_out = 1'b0;
    end

    // Read data for the next cycle, zero for unmapped offsets
    n.rdata = 32'h0000_0000;
    if (rd_ok) begin
      case (ADDR)
        calendar_clock_unit_pkg::OFS_CTRL: n.rdata = ctrl_word;
        calendar_clock_unit_pkg::OFS_TIME: n.rdata = {time_value, 8'h00};
        calendar_clock_unit_pkg::OFS_INT_STAT: n.rdata = {29'h0000_0000, s.int_stat};
        calendar_clock_unit_pkg::OFS_INT_MASK: n.rdata = {29'h0000_0000, s.int_mask};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; only the power-on reset reaches it

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign RDATA = s.rdata;
  assign RTC_PIN_OUT = s.pin_out;
  assign RTC_PIN_OE = s.oe;
  assign BUS_CLK_EN = s.bus_clk_en;
  assign IRQ = |(s.int_stat & s.int_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chk_on_locked: assert property (
    wr_ok && ADDR == calendar_clock_unit_pkg::OFS_CTRL && !s.unlock |=> s.on == $past(s.on))
    else $error("enable changed while locked");

  chk_unlock_gate: assert property (
    wr_ok && ADDR == calendar_clock_unit_pkg::OFS_CTRL && !SYS_WRITE_UNLOCKED && !s.unlock |=> !s.unlock)
    else $error("unlock set without system sequence");

  chk_time_locked: assert property (
    wr_ok && ADDR == calendar_clock_unit_pkg::OFS_TIME && !s.unlock && !sec_pulse
      |=> time_value == $past(time_value))
    else $error("time changed by a locked write");

  chk_half_clear: assert property (
    time_load |=> !half_flag)
    else $error("half flag survived a seconds write");

  // Read path shows the live half flag and time digits
  chk_half_read: assert property (
    rd_ok && ADDR == calendar_clock_unit_pkg::OFS_CTRL |=> RDATA[calendar_clock_unit_pkg::CTRL_HALF_BIT] == $past(half_flag))
    else $error("half flag read back wrong");

  chk_time_read: assert property (
    rd_ok && ADDR == calendar_clock_unit_pkg::OFS_TIME |=> RDATA[31:8] == $past(time_value))
    else $error("time digits read back wrong");

  // Idle read data stays at zero
  chk_rdata_quiet: assert property (
    !rd_ok |=> RDATA == 32'h0000_0000)
    else $error("read data without a read");

  chk_pin_quiet: assert property (
    !s.oe |=> !RTC_PIN_OUT)
    else $error("pin driven while output disabled");

  chk_pin_select: assert property (
    s.oe && s.sel |=> RTC_PIN_OUT == $past(half_flag))
    else $error("pin not following the seconds clock");

  chk_pin_alarm: assert property (
    s.oe && !s.sel |=> RTC_PIN_OUT == $past(ALARM_PULSE))
    else $error("pin not following the alarm pulse");

  // Disabled unit neither runs nor counts
  chk_off_stops: assert property (
    !s.on |=> !s.running)
    else $error("running shown while disabled");

  chk_time_hold: assert property (
    !s.on && !time_load && !sec_pulse |=> time_value == $past(time_value))
    else $error("time advanced while disabled");

  chk_unlock_clear: assert property (
    wr_ok && ADDR == calendar_clock_unit_pkg::OFS_CTRL && !WDATA[calendar_clock_unit_pkg::CTRL_UNLOCK_BIT] |=> !s.unlock)
    else $error("unlock survived a clearing write");

  chk_run_status: assert property (
    s.running |-> s.on && s.run_cnt != '0)
    else $error("running shown while stopped");

  chk_reserved_zero: assert property (
    rd_ok && ADDR == calendar_clock_unit_pkg::OFS_CTRL |=> (RDATA & calendar_clock_unit_pkg::CTRL_RSVD_MASK) == 32'h0000_0000)
    else $error("unimplemented control bits read nonzero");

  chk_time_low_zero: assert property (
    rd_ok && ADDR == calendar_clock_unit_pkg::OFS_TIME |=> RDATA[7:0] == 8'h00 && RDATA[31:28] <= 4'h2)
    else $error("time register low byte or hours tens wrong");

  chk_idle_gate: assert property (
    s.idle_halt && CPU_IDLE && !(WR && ADDR == calendar_clock_unit_pkg::OFS_CTRL) |=> !BUS_CLK_EN)
    else $error("bus clock not gated in idle");

  chk_bus_open: assert property (
    !s.idle_halt && !(wr_ok && ADDR == calendar_clock_unit_pkg::OFS_CTRL) |=> BUS_CLK_EN)
    else $error("bus clock gated without idle halt");

  // Every event lands in its sticky status bit
  chk_sec_stat: assert property (
    sec_pulse |=> s.int_stat[calendar_clock_unit_pkg::EV_SEC])
    else $error("second event not recorded");

  chk_minute_stat: assert property (
    minute_roll |=> s.int_stat[calendar_clock_unit_pkg::EV_MIN])
    else $error("minute event not recorded");

  chk_alarm_stat: assert property (
    alarm_rise |=> s.int_stat[calendar_clock_unit_pkg::EV_ALARM])
    else $error("alarm event not recorded");

  chk_irq_masked: assert property (
    s.int_mask == '0 |-> !IRQ)
    else $error("interrupt raised with all sources masked");

  chk_stat_sticky: assert property (
    s.int_stat[calendar_clock_unit_pkg::EV_SEC] && !(wr_ok && ADDR == calendar_clock_unit_pkg::OFS_INT_STAT)
      |=> s.int_stat[calendar_clock_unit_pkg::EV_SEC])
    else $error("status bit lost without a clear");

  cov_time_load: cover property (time_load ##[1:1000] sec_pulse);
  cov_drop_trim: cover property (minute_roll && s.trim[calendar_clock_unit_pkg::TRIM_W-1]);
  cov_idle_gated: cover property (!BUS_CLK_EN && CPU_IDLE);
  cov_minute: cover property (minute_roll);
  cov_irq: cover property ($rose(IRQ));

endmodule : rtc_control_calibration

// file: rtl/rtc_prescaler.sv
`timescale 1ns/10ps
module rtc_prescaler #(
  parameter int TICKS_PER_SEC = calendar_clock_unit_pkg::TICKS_PER_SEC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timebase and control
  input wire logic tick,
  input wire logic run,
  input wire logic [calendar_clock_unit_pkg::TRIM_W-1:0] trim,
  input wire logic minute_roll,
  input wire logic clear_half,
  // Status
  output logic sec_pulse,
  output logic half_flag,
  output logic near_roll
);

  typedef struct packed {
    logic [15:0] count;
    logic [calendar_clock_unit_pkg::TRIM_W-1:0] pending;
    calendar_clock_unit_pkg::trim_mode_e mode;
    logic half;
    logic sec_pulse;
  } presc_state_s;

  presc_state_s s;
  presc_state_s n;
  logic [1:0] step;
  logic [16:0] sum;

  // Trim load, tick counting and half-second tracking
  always_comb begin
    n = s;
    n.sec_pulse = 1'b0;
    step = 2'd1;
    sum = 17'h0_0000;
    if (minute_roll) begin
      if (trim[calendar_clock_unit_pkg::TRIM_W-1]) begin
        n.mode = calendar_clock_unit_pkg::TRIM_DROP;
        n.pending = calendar_clock_unit_pkg::TRIM_W'(-trim);
      end else if (trim != '0) begin
        n.mode = calendar_clock_unit_pkg::TRIM_ADD;
        n.pending = trim;
      end else begin
        n.mode = calendar_clock_unit_pkg::TRIM_IDLE;
        n.pending = '0;
      end
    end
    if (clear_half) begin
      n.count = 16'h0000;
      n.half = 1'b0;
    end else if (run && tick) begin
      case (s.mode)
        calendar_clock_unit_pkg::TRIM_ADD: begin
          step = 2'd2;
          n.pending = s.pending - 1'b1;
          if (s.pending <= 1) n.mode = calendar_clock_unit_pkg::TRIM_IDLE;
        end
        calendar_clock_unit_pkg::TRIM_DROP: begin
          step = 2'd0;
          n.pending = s.pending - 1'b1;
          if (s.pending <= 1) n.mode = calendar_clock_unit_pkg::TRIM_IDLE;
        end
        default: step = 2'd1;
      endcase
      sum = {1'b0, s.count} + {15'h0000, step};
      if (sum >= 17'(TICKS_PER_SEC)) begin
        sum = sum - 17'(TICKS_PER_SEC);
        n.sec_pulse = 1'b1;
      end
      n.count = sum[15:0];
      n.half = (sum >= 17'(TICKS_PER_SEC / 2));
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sec_pulse = s.sec_pulse;
  assign half_flag = s.half;
  assign near_roll = (s.count >= 16'(TICKS_PER_SEC - calendar_clock_unit_pkg::SYNC_WINDOW_TICKS));

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_drop_tick: assert property (
    s.mode == calendar_clock_unit_pkg::TRIM_DROP && run && tick && !clear_half |=> s.count == $past(s.count))
    else $error("dropped tick still advanced the prescaler");
  chk_zero_trim: assert property (
    minute_roll && trim == '0 |=> s.mode == calendar_clock_unit_pkg::TRIM_IDLE)
    else $error("zero trim started a correction");
  chk_half_cleared: assert property (
    clear_half |=> !s.half && s.count == 16'h0000)
    else $error("half-second flag not cleared");

endmodule : rtc_prescaler

// file: tb/test_rtc_control_calibration.sv
`timescale 1ns/10ps
module test_rtc_control_calibration;
  localparam int TPS = 128;
  localparam logic [7:0] A_CTL = calendar_clock_unit_pkg::OFS_CTRL;
  localparam logic [7:0] A_TIM = calendar_clock_unit_pkg::OFS_TIME;
  localparam logic [7:0] A_STA = calendar_clock_unit_pkg::OFS_INT_STAT;
  localparam logic [7:0] A_MSK = calendar_clock_unit_pkg::OFS_INT_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sys_unl = 1'b0;
  logic cpu_idle = 1'b0;
  logic alarm = 1'b0;
  logic tb_in = 1'b0;
  logic [31:0] rdata;
  logic pin_out;
  logic pin_oe;
  logic bus_en;
  logic irq;
  int err_total = 0;
  int checks_done = 0;

  // Core clock, 40 ns period
  always #20 core_clk = ~core_clk;

  // Short second keeps the run brief
  rtc_control_calibration #(.TICKS_PER_SEC(TPS)) dut (
    .CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SYS_WRITE_UNLOCKED(sys_unl), .CPU_IDLE(cpu_idle),
    .ALARM_PULSE(alarm), .TIMEBASE_IN(tb_in), .RTC_PIN_OUT(pin_out),
    .RTC_PIN_OE(pin_oe), .BUS_CLK_EN(bus_en), .IRQ(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : rd_reg

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask : expect_reg

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc

  // Timebase pulses, spaced well past the synchroniser depth
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      tb_in <= 1'b1;
      wait_cyc(3);
      tb_in <= 1'b0;
      wait_cyc(3);
    end
  endtask : tick

  // Ticks needed until the seconds digits move
  task automatic count_sec(output int n);
    logic [31:0] s;
    logic [31:0] v;
    n = 0;
    rd_reg(A_TIM, s);
    v = s;
    while (v === s && n < 400) begin
      tick(1);
      rd_reg(A_TIM, v);
      n++;
    end
  endtask : count_sec

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    expect_reg(A_CTL, 32'h0000_0000);
    expect_reg(A_TIM, 32'h0000_0000);
    expect_reg(A_STA, 32'h0000_0000);
    expect_reg(A_MSK, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
  endtask : t_reset

  task automatic t_lock();
    wr_reg(A_CTL, 32'h0000_8008);
    expect_reg(A_CTL, 32'h0000_0000);
    wr_reg(A_TIM, 32'h1234_5600);
    expect_reg(A_TIM, 32'h0000_0000);
    @(posedge core_clk);
    sys_unl <= 1'b1;
    wr_reg(A_CTL, 32'h0000_8000);
    expect_reg(A_CTL, 32'h0000_0000);
    wr_reg(A_CTL, 32'h0000_0008);
    expect_reg(A_CTL, 32'h0000_0008);
    @(posedge core_clk);
    sys_unl <= 1'b0;
    wr_reg(A_CTL, 32'hFFFF_FFFF);
    expect_reg(A_CTL, 32'h03FF_A089);
    chk({31'h0000_0000, pin_oe}, 32'h0000_0001);
    wr_reg(A_TIM, 32'h2359_58FF);
    expect_reg(A_TIM, 32'h2359_5800);
  endtask : t_lock

  task automatic t_pin();
    wr_reg(A_CTL, 32'h0000_8009);
    @(posedge core_clk);
    alarm <= 1'b1;
    wait_cyc(3);
    chk({31'h0000_0000, pin_out}, 32'h0000_0001);
    wr_reg(A_CTL, 32'h0000_8008);
    wait_cyc(2);
    chk({30'h0000_0000, pin_oe, pin_out}, 32'h0000_0000);
    alarm <= 1'b0;
    wr_reg(A_CTL, 32'h0000_8089);
    wr_reg(A_TIM, 32'h0000_0000);
    tick(TPS / 2 - 1);
    expect_reg(A_CTL, 32'h0000_80C9);
    tick(1);
    expect_reg(A_CTL, 32'h0000_80CB);
    chk({31'h0000_0000, pin_out}, 32'h0000_0001);
    wr_reg(A_TIM, 32'h0000_0500);
    expect_reg(A_CTL, 32'h0000_80C9);
    wait_cyc(1600);
    expect_reg(A_CTL, 32'h0000_8089);
  endtask : t_pin

  task automatic t_idle();
    wr_reg(A_CTL, 32'h0000_A008);
    cpu_idle <= 1'b1;
    wait_cyc(3);
    chk({31'h0000_0000, bus_en}, 32'h0000_0000);
    expect_reg(A_CTL, 32'h0000_0000);
    cpu_idle <= 1'b0;
    wait_cyc(3);
    chk({31'h0000_0000, bus_en}, 32'h0000_0001);
    wr_reg(A_CTL, 32'h0000_8008);
    cpu_idle <= 1'b1;
    wait_cyc(3);
    chk({31'h0000_0000, bus_en}, 32'h0000_0001);
    expect_reg(A_CTL, 32'h0000_8008);
    cpu_idle <= 1'b0;
  endtask : t_idle

  task automatic t_irq();
    wr_reg(A_STA, 32'h0000_0007);
    wr_reg(A_MSK, 32'h0000_0004);
    expect_reg(A_STA, 32'h0000_0000);
    @(posedge core_clk);
    alarm <= 1'b1;
    @(posedge core_clk);
    alarm <= 1'b0;
    wait_cyc(3);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    expect_reg(A_STA, 32'h0000_0004);
    wr_reg(A_MSK, 32'h0000_0000);
    wait_cyc(2);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr_reg(A_MSK, 32'h0000_0004);
    wr_reg(A_STA, 32'h0000_0004);
    wait_cyc(2);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    expect_reg(A_STA, 32'h0000_0000);
    expect_reg(8'h10, 32'h0000_0000);
  endtask : t_irq

  // Second after each minute rollover is trimmed by the signed count
  task automatic t_trim();
    logic [9:0] tv [4] = '{10'h005, 10'h3FF, 10'h000, 10'h3F8};
    logic [31:0] v;
    int n;
    for (int i = 0; i < 4; i++) begin
      wr_reg(A_CTL, {6'h00, tv[i], 16'h8008});
      wr_reg(A_TIM, 32'h0959_5900);
      count_sec(n);
      chk(32'(n), 32'(TPS));
      expect_reg(A_TIM, 32'h1000_0000);
      count_sec(n);
      chk(32'(n), 32'(TPS - int'($signed(tv[i]))));
    end
    // Task spacing leaves idle cycles after disabling
    wr_reg(A_CTL, 32'h0000_0008);
    rd_reg(A_TIM, v);
    tick(TPS + 8);
    expect_reg(A_TIM, v);
  endtask : t_trim

  task automatic t_por();
    @(posedge core_clk);
    rst <= 1'b1;
    wait_cyc(5);
    rst <= 1'b0;
    wait_cyc(2);
    expect_reg(A_CTL, 32'h0000_0000);
    expect_reg(A_TIM, 32'h0000_0000);
  endtask : t_por

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    wait_cyc(5);
    rst <= 1'b0;
    wait_cyc(2);
    t_reset();
    t_lock();
    t_pin();
    t_idle();
    t_irq();
    t_trim();
    t_por();
    wrap_up();
  end

  // Watchdog against a hang
  initial begin
    wait_cyc(60000);
    err_total++;
    wrap_up();
  end
endmodule : test_rtc_control_calibration
